// file: logic/fsc_top.sv
// Flash supervisory call engine: key check, program, clear, protect, table fetch, wipe
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_cfg.svh"

module fsc_top
  import fsc_pkg::*;
#(
  parameter int          NUM_BLOCKS     = 256,
  parameter logic [7:0]  DIE_REVISION   = 8'h5a, // Arbitrary value
  parameter logic [255:0] FACTORY_TABLES = {32{8'ha5}} // Arbitrary contents
) (
  // Clock, reset, enable
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  // Register port
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic      [7:0]             o_reg_rdata,
  // Caller context
  input  wire logic                   i_external,
  input  wire logic [7:0]             i_stack_ptr,
  // SRAM port
  output fsc_sram_req_type            o_sram,
  input  wire logic [7:0]             i_sram_rdata,
  // Table read instruction port
  input  wire logic                   i_tbl_rd,
  input  wire logic [$clog2(NUM_BLOCKS*`FSC_BLOCK_BYTES)-1:0] i_tbl_addr,
  output logic      [7:0]             o_tbl_data,
  // Call state
  output logic      [7:0]             o_acc,
  output logic                        o_busy,
  output logic                        o_halt
);

  localparam int FLASH_BYTES = NUM_BLOCKS * `FSC_BLOCK_BYTES;
  localparam int FAW         = $clog2(FLASH_BYTES);
  localparam int BW          = $clog2(NUM_BLOCKS);
  localparam int PROT_BYTES  = NUM_BLOCKS / 4;
  localparam logic [FAW-1:0] FLASH_LAST = FAW'(FLASH_BYTES - 1);
  localparam logic [6:0] BLOCK_LAST = 7'(`FSC_BLOCK_BYTES - 1);
  localparam logic [6:0] PROT_LAST  = 7'(PROT_BYTES - 1);
  localparam logic [6:0] TABLE_LAST = 7'(`FSC_TABLE_BYTES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // A write is refused by mode 11 from inside, and by 10 or 11 from outside
  function automatic logic write_blocked(input logic [1:0] mode, input logic ext);
    if (ext) begin
      write_blocked = mode[1];
    end else begin
      write_blocked = (mode == `FSC_PROT_INTW);
    end
  endfunction : write_blocked

  function automatic logic [FAW-1:0] flash_index(input logic [BW-1:0] blk,
                                                 input logic [6:0] ofs);
    flash_index = {blk, ofs};
  endfunction : flash_index

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0]   flash_mem [FLASH_BYTES];
  logic [1:0]   prot_mode [NUM_BLOCKS];
  logic         fl_we;
  logic [FAW-1:0] fl_addr;
  logic [7:0]   fl_data;
  logic         prot_we;
  logic         prot_clear;
  logic [6:0]   prot_byte_idx;
  logic [7:0]   prot_byte;

  // Array has no reset: it stands for non-volatile cells
  always_ff @(posedge i_clk) begin
    if (i_ce && fl_we) begin
      flash_mem[fl_addr] <= fl_data;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        prot_mode[i] <= `FSC_PROT_NONE;
      end
    end else if (i_ce) begin
      if (prot_clear) begin
        for (int i = 0; i < NUM_BLOCKS; i++) begin
          prot_mode[i] <= `FSC_PROT_NONE;
        end
      end else if (prot_we) begin
        for (int j = 0; j < 4; j++) begin
          prot_mode[{prot_byte_idx[BW-3:0], 2'(j)}] <= prot_byte[2*j +: 2];
        end
      end
    end
  end

  // Table reads ignore protection altogether
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tbl_data <= 8'h00;
    end else if (i_ce && i_tbl_rd) begin
      o_tbl_data <= flash_mem[i_tbl_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [7:0] page_reg;
  logic       call_go;
  logic [7:0] call_fn;
  logic       fail_flag;
  fsc_state_type state;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `FSC_PAGE_RST;
      call_go  <= 1'b0;
      call_fn  <= 8'h00;
    end else if (i_ce) begin
      call_go <= 1'b0;
      if (i_reg_wr) begin
        if (i_reg_addr == `FSC_REG_PAGE) begin
          page_reg <= i_reg_wdata;
        end else if (i_reg_addr == `FSC_REG_CALL && state == FSC_IDLE && !call_go) begin
          call_go <= 1'b1;
          call_fn <= i_reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      if (!i_reg_rd) begin
        o_reg_rdata <= 8'h00;
      end else if (i_reg_addr == `FSC_REG_PAGE) begin
        o_reg_rdata <= page_reg;
      end else if (i_reg_addr == `FSC_REG_STATUS) begin
        o_reg_rdata <= {5'h00, o_halt, fail_flag, o_busy};
      end else if (i_reg_addr == `FSC_REG_ACC) begin
        o_reg_rdata <= o_acc;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  fsc_state_type after;
  fsc_call_type  call;
  logic [7:0]    rdata_q;
  logic          first_key_byte_ok;
  logic [BW-1:0] blk;
  logic [7:0]    ptr;
  logic [6:0]    cnt;
  logic [FAW-1:0] wcnt;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= FSC_IDLE;
      after         <= FSC_IDLE;
      call          <= '0;
      rdata_q       <= 8'h00;
      first_key_byte_ok       <= 1'b0;
      blk           <= '0;
      ptr           <= 8'h00;
      cnt           <= 7'h00;
      wcnt          <= '0;
      o_sram        <= '0;
      o_acc         <= 8'h00;
      o_busy        <= 1'b0;
      o_halt        <= 1'b0;
      fail_flag     <= 1'b0;
      fl_we         <= 1'b0;
      fl_addr       <= '0;
      fl_data       <= 8'h00;
      prot_we       <= 1'b0;
      prot_clear    <= 1'b0;
      prot_byte_idx <= 7'h00;
      prot_byte     <= 8'h00;
    end else if (i_ce) begin
      o_sram.rd  <= 1'b0;
      o_sram.wr  <= 1'b0;
      fl_we      <= 1'b0;
      prot_we    <= 1'b0;
      prot_clear <= 1'b0;
      case (state)
        FSC_IDLE: begin
          if (call_go) begin
            call          <= '{fn: call_fn, external: i_external};
            o_busy        <= 1'b1;
            o_sram        <= '{rd: 1'b1, wr: 1'b0, page: 8'h00,
                               addr: `FSC_PB_FIRST_KEY_BYTE, wdata: 8'h00};
            after         <= FSC_FIRST_KEY_BYTE;
            state         <= FSC_WAIT;
          end
        end
        // Strobe cycle, then the data cycle in which rdata is taken
        FSC_WAIT: begin
          state <= FSC_TAKE;
        end
        FSC_TAKE: begin
          rdata_q <= i_sram_rdata;
          state   <= after;
        end
        FSC_FIRST_KEY_BYTE: begin
          first_key_byte_ok <= (rdata_q == `FSC_FIRST_KEY_BYTE_VAL);
          o_sram  <= '{rd: 1'b1, wr: 1'b0, page: 8'h00,
                       addr: `FSC_PB_SECOND_KEY_BYTE, wdata: 8'h00};
          after   <= FSC_SECOND_KEY_BYTE;
          state   <= FSC_WAIT;
        end
        FSC_SECOND_KEY_BYTE: begin
          if (!first_key_byte_ok || rdata_q != 8'(i_stack_ptr + `FSC_SP_OFFSET)) begin
            state <= FSC_FAIL1;
          end else if (call.fn == `FSC_FN_WIPE) begin
            if (!call.external) begin
              state <= FSC_HALT;
            end else begin
              wcnt  <= '0;
              state <= FSC_WIPE;
            end
          end else if (call.fn == `FSC_FN_PROGRAM || call.fn == `FSC_FN_CLEAR ||
                       call.fn == `FSC_FN_PROTECT || call.fn == `FSC_FN_TABLE) begin
            o_sram <= '{rd: 1'b1, wr: 1'b0, page: 8'h00,
                        addr: `FSC_PB_BLOCK, wdata: 8'h00};
            after  <= FSC_BLOCK;
            state  <= FSC_WAIT;
          end else begin
            state <= FSC_FAIL1;
          end
        end
        FSC_BLOCK: begin
          blk <= rdata_q[BW-1:0];
          cnt <= 7'h00;
          if (call.fn == `FSC_FN_CLEAR) begin
            if (write_blocked(prot_mode[rdata_q[BW-1:0]], call.external)) begin
              state <= FSC_FAIL1;
            end else begin
              state <= FSC_CLEAR;
            end
          end else if (call.fn == `FSC_FN_TABLE) begin
            state <= FSC_TABLE;
          end else begin
            o_sram <= '{rd: 1'b1, wr: 1'b0, page: 8'h00,
                        addr: `FSC_PB_PTR, wdata: 8'h00};
            after  <= FSC_PTR;
            state  <= FSC_WAIT;
          end
        end
        FSC_PTR: begin
          ptr <= rdata_q;
          if (call.fn == `FSC_FN_PROGRAM &&
              write_blocked(prot_mode[blk], call.external)) begin
            state <= FSC_FAIL1;
          end else begin
            state <= FSC_SRC;
          end
        end
        FSC_SRC: begin
          o_sram <= '{rd: 1'b1, wr: 1'b0, page: page_reg,
                      addr: 8'(ptr + {1'b0, cnt}), wdata: 8'h00};
          after  <= FSC_PUT;
          state  <= FSC_WAIT;
        end
        FSC_PUT: begin
          if (call.fn == `FSC_FN_PROGRAM) begin
            fl_we   <= 1'b1;
            fl_addr <= flash_index(blk, cnt);
            fl_data <= rdata_q;
            state   <= (cnt == BLOCK_LAST) ? FSC_DONE : FSC_SRC;
          end else begin
            prot_we       <= 1'b1;
            prot_byte_idx <= cnt;
            prot_byte     <= rdata_q;
            state         <= (cnt == PROT_LAST) ? FSC_DONE : FSC_SRC;
          end
          cnt <= cnt + 7'h01;
        end
        FSC_CLEAR: begin
          fl_we   <= 1'b1;
          fl_addr <= flash_index(blk, cnt);
          fl_data <= 8'h00;
          cnt     <= cnt + 7'h01;
          if (cnt == BLOCK_LAST) begin
            state <= FSC_DONE;
          end
        end
        // Table bytes land over the parameter block, page 0
        FSC_TABLE: begin
          o_sram <= '{rd: 1'b0, wr: 1'b1, page: 8'h00,
                      addr: 8'(`FSC_TBL_DEST + {1'b0, cnt}),
                      wdata: FACTORY_TABLES[{blk[1:0], cnt[2:0], 3'h0} +: 8]};
          cnt    <= cnt + 7'h01;
          if (cnt == TABLE_LAST) begin
            o_acc <= DIE_REVISION;
            state <= FSC_DONE;
          end
        end
        // Hidden blocks and factory tables are outside this array
        FSC_WIPE: begin
          fl_we   <= 1'b1;
          fl_addr <= wcnt;
          fl_data <= 8'h00;
          wcnt    <= wcnt + FAW'(1);
          if (wcnt == FLASH_LAST) begin
            prot_clear <= 1'b1;
            state      <= FSC_DONE;
          end
        end
        FSC_FAIL1: begin
          o_sram <= '{rd: 1'b0, wr: 1'b1, page: 8'h00,
                      addr: `FSC_PB_FIRST_KEY_BYTE, wdata: `FSC_FAIL_FIRST_KEY_BYTE};
          state  <= FSC_FAIL2;
        end
        FSC_FAIL2: begin
          o_sram    <= '{rd: 1'b0, wr: 1'b1, page: 8'h00,
                         addr: `FSC_PB_SECOND_KEY_BYTE, wdata: `FSC_FAIL_ZERO};
          o_acc     <= `FSC_FAIL_ZERO;
          fail_flag <= 1'b1;
          o_busy    <= 1'b0;
          state     <= FSC_IDLE;
        end
        FSC_DONE: begin
          if (call.fn != `FSC_FN_TABLE) begin
            o_acc <= 8'h00;
          end
          fail_flag <= 1'b0;
          o_busy    <= 1'b0;
          state     <= FSC_IDLE;
        end
        // Only a reset leaves a halt
        FSC_HALT: begin
          o_halt <= 1'b1;
        end
        default: begin
          state <= FSC_IDLE;
        end
      endcase
    end
  end

endmodule : fsc_top
`default_nettype wire

// file: common/fsc_cfg.svh
// Constants of the flash supervisory call engine
// Operation
// - Block programming takes its 128 source bytes from consecutive SRAM addresses starting at the pointer byte at FBh.
// - The SRAM page feeding block programming is chosen by the indirect read page register at D4h.
// - Block clear sets all 128 bytes of the chosen flash block to 00h.
// - A protected block clear changes no flash and leaves accumulator and second key at 00h and first key at 01h.
// - Every flash block has its own two-bit protection mode from unprotected to internal writes disabled.
// - Protection modes pack four blocks to a byte with block n in bits 1:0 up to block n+3 in bits 7:6.
// - Table reads of flash by the processor are always allowed whatever the block's protection mode.
// - Full wipe destroys all user flash data and returns every block to the unprotected mode.
// - Full wipe works only for the external programmer and a processor request halts with nothing changed.
// - Full wipe leaves the three hidden blocks above the protection block alone.
// - Factory table fetch returns one of four 8-byte tables picked by the block number and a die revision.
// - Function codes are 02h block program, 03h block clear and 05h full wipe.
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

// Register port offsets
`define FSC_REG_PAGE    8'hd4
`define FSC_REG_CALL    8'he0
`define FSC_REG_STATUS  8'he1
`define FSC_REG_ACC     8'he2

// Parameter block, SRAM page 0
`define FSC_PB_FIRST_KEY_BYTE     8'hf8
`define FSC_PB_SECOND_KEY_BYTE     8'hf9
`define FSC_PB_BLOCK    8'hfa
`define FSC_PB_PTR      8'hfb
`define FSC_TBL_DEST    8'hf8

// Key values and results
`define FSC_FIRST_KEY_BYTE_VAL    8'h3a
`define FSC_SP_OFFSET   8'h03
`define FSC_FAIL_FIRST_KEY_BYTE   8'h01
`define FSC_FAIL_ZERO   8'h00

// Function codes
`define FSC_FN_PROGRAM  8'h02
`define FSC_FN_CLEAR    8'h03
`define FSC_FN_PROTECT  8'h04
`define FSC_FN_WIPE     8'h05
`define FSC_FN_TABLE    8'h06

// Protection modes
`define FSC_PROT_NONE   2'h0
`define FSC_PROT_READ   2'h1
`define FSC_PROT_EXTW   2'h2
`define FSC_PROT_INTW   2'h3

// Sizes, reset values and status bit positions
`define FSC_BLOCK_BYTES 128
`define FSC_TABLE_BYTES 8
`define FSC_PAGE_RST    8'h00
`define FSC_STATUS_BUSY 0
`define FSC_STATUS_FAIL 1
`define FSC_STATUS_HALT 2

`endif

// file: common/fsc_pkg.sv
// Types of the flash supervisory call engine
package fsc_pkg;

  typedef enum logic [3:0] {
    FSC_IDLE,
    FSC_WAIT,
    FSC_TAKE,
    FSC_FIRST_KEY_BYTE,
    FSC_SECOND_KEY_BYTE,
    FSC_BLOCK,
    FSC_PTR,
    FSC_SRC,
    FSC_PUT,
    FSC_CLEAR,
    FSC_TABLE,
    FSC_WIPE,
    FSC_FAIL1,
    FSC_FAIL2,
    FSC_DONE,
    FSC_HALT
  } fsc_state_type;

  // One SRAM access as driven on the SRAM port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsc_sram_req_type;

  // Latched call request
  typedef struct packed {
    logic [7:0] fn;
    logic       external;
  } fsc_call_type;

endpackage : fsc_pkg

// file: test/fsc_top_properties.sv
// Port checker for the flash supervisory call engine
`timescale 1ns/1ps
`default_nettype none
`include "fsc_cfg.svh"
module fsc_top_properties
  import fsc_pkg::*;
#(
  parameter int NUM_BLOCKS = 256
) (
  // Clock, reset, enable
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  input wire logic             i_ce,
  // Register port
  input wire logic [7:0]       i_reg_addr,
  input wire logic [7:0]       i_reg_wdata,
  input wire logic             i_reg_wr,
  input wire logic             i_reg_rd,
  input wire logic [7:0]       o_reg_rdata,
  // Caller and SRAM
  input wire logic             i_external,
  input wire logic [7:0]       i_stack_ptr,
  input wire fsc_sram_req_type o_sram,
  input wire logic [7:0]       i_sram_rdata,
  // Table reads and call state
  input wire logic             i_tbl_rd,
  input wire logic [$clog2(NUM_BLOCKS*`FSC_BLOCK_BYTES)-1:0] i_tbl_addr,
  input wire logic [7:0]       o_tbl_data,
  input wire logic [7:0]       o_acc,
  input wire logic             o_busy,
  input wire logic             o_halt
);
  logic [7:0] page_shadow;
  logic       call_wr;
  logic [1:0] rst_seen;
  logic       chk_rst_n;

  // Follow the engine's own two-flop reset release, so both leave reset together
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_seen <= 2'h0;
    end else begin
      rst_seen <= {rst_seen[0], 1'b1};
    end
  end
  assign chk_rst_n = rst_seen[1];

  // Shadow of the source page register, rebuilt from port writes
  always_ff @(posedge i_clk or negedge chk_rst_n) begin
    if (!chk_rst_n) begin
      page_shadow <= `FSC_PAGE_RST;
    end else if (i_ce && i_reg_wr && i_reg_addr == `FSC_REG_PAGE) begin
      page_shadow <= i_reg_wdata;
    end
  end
  assign call_wr = i_ce && i_reg_wr && i_reg_addr == `FSC_REG_CALL;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!chk_rst_n);

  // A frozen clock enable holds the last read answer in place
  a_rdata_idle: assert property ($past(i_ce) && !$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_page_readback: assert property ($past(i_ce && i_reg_rd && i_reg_addr == `FSC_REG_PAGE) |->
    o_reg_rdata == $past(page_shadow)) else $error("page register readback wrong");
  a_source_page: assert property (o_sram.rd && o_sram.page != 8'h00 |->
    o_sram.page == page_shadow) else $error("source read from wrong page");
  a_fail_report: assert property (o_sram.wr && o_sram.addr == `FSC_PB_FIRST_KEY_BYTE &&
    o_sram.wdata == `FSC_FAIL_FIRST_KEY_BYTE |=> o_sram.wr && o_sram.addr == `FSC_PB_SECOND_KEY_BYTE &&
    o_sram.wdata == 8'h00 ##[1:8] (!o_busy && o_acc == 8'h00))
    else $error("failure report sequence wrong");
  a_sram_exclusive: assert property (!(o_sram.rd && o_sram.wr))
    else $error("sram read and write together");
  a_sram_wr_area: assert property (o_sram.wr |-> o_sram.page == 8'h00 &&
    o_sram.addr >= `FSC_PB_FIRST_KEY_BYTE) else $error("sram write outside parameter block");
  a_halt_sticky: assert property (o_halt |=> o_halt)
    else $error("halt dropped");
  a_halt_quiet: assert property (o_halt |-> !o_sram.wr && !o_sram.rd)
    else $error("sram traffic while halted");
  a_call_start: assert property (call_wr && !o_busy && !o_halt && !$past(call_wr)
    |-> ##[1:3] o_busy) else $error("call did not start");
  a_table_hold: assert property (!$past(i_tbl_rd) |-> $stable(o_tbl_data))
    else $error("table data changed without read");

  c_halted: cover property (o_halt);
  c_failed: cover property (o_sram.wr && o_sram.addr == `FSC_PB_FIRST_KEY_BYTE && o_sram.wdata == 8'h01);
  c_source: cover property (o_sram.rd && o_sram.page != 8'h00);
endmodule : fsc_top_properties

bind fsc_top fsc_top_properties #(.NUM_BLOCKS(NUM_BLOCKS)) fsc_top_properties_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_external(i_external), .i_stack_ptr(i_stack_ptr),
  .o_sram(o_sram), .i_sram_rdata(i_sram_rdata), .i_tbl_rd(i_tbl_rd),
  .i_tbl_addr(i_tbl_addr), .o_tbl_data(o_tbl_data), .o_acc(o_acc), .o_busy(o_busy),
  .o_halt(o_halt));
`default_nettype wire

// file: test/fsc_sram_model.sv
// Behavioural SRAM answering the engine's SRAM port
`timescale 1ns/1ps
`default_nettype none
module fsc_sram_model
  import fsc_pkg::*;
(
  // Clock
  input wire logic             i_clk,
  // Engine request and answer
  input wire fsc_sram_req_type i_req,
  output var logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];

  initial o_rdata = 8'h00;
  // Data stands one cycle only; otherwise it toggles so stale use shows
  always @(posedge i_clk) begin
    if (i_req.rd) begin
      o_rdata <= mem[{i_req.page, i_req.addr}];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_req.wr) begin
      mem[{i_req.page, i_req.addr}] <= i_req.wdata;
    end
  end
endmodule : fsc_sram_model
`default_nettype wire

// file: test/fsc_top_bench.sv
// Self-checking bench for the flash supervisory call engine
`timescale 1ns/1ps
`default_nettype none
`include "fsc_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module fsc_top_bench
  import fsc_pkg::*;
;
  logic clk, rst_n, reg_wr, reg_rd, ext, tbl_rd, busy, halt, ce;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sp, sram_rdata, tbl_data, acc;
  logic [9:0] tbl_addr;
  fsc_sram_req_type sram;
  int miscompares, check_count, cycles;
  localparam logic [7:0] PTR = 8'hc0;

  fsc_top #(.NUM_BLOCKS(8), .DIE_REVISION(8'h6b), // Arbitrary revision
    .FACTORY_TABLES(256'h1f1e1d1c1b1a191817161514131211100f0e0d0c0b0a09080706050403020100))
  fsc_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_external(ext), .i_stack_ptr(sp), .o_sram(sram), .i_sram_rdata(sram_rdata),
    .i_tbl_rd(tbl_rd), .i_tbl_addr(tbl_addr), .o_tbl_data(tbl_data), .o_acc(acc),
    .o_busy(busy), .o_halt(halt));
  fsc_sram_model fsc_sram_model_inst (.i_clk(clk), .i_req(sram), .o_rdata(sram_rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus_rd

  task automatic tbl_read(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    tbl_rd <= 1'b1;
    tbl_addr <= a;
    @(posedge clk);
    tbl_rd <= 1'b0;
    #1 d = tbl_data;
  endtask : tbl_read

  task automatic do_call(input logic [7:0] fn, input logic x, input logic [7:0] blk,
                         input logic [7:0] k1, input logic [7:0] k2);
    int n;
    fsc_sram_model_inst.mem[16'h00f8] = k1;
    fsc_sram_model_inst.mem[16'h00f9] = sp + k2;
    fsc_sram_model_inst.mem[16'h00fa] = blk;
    fsc_sram_model_inst.mem[16'h00fb] = PTR;
    @(posedge clk);
    ext <= x;
    bus_wr(`FSC_REG_CALL, fn);
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && halt !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK("call end", 1'b1, n < 5000)
    #1;
  endtask : do_call

  // Failure leaves the keys rewritten and the accumulator cleared
  task automatic call_chk(input logic [7:0] fn, input logic x, input logic [7:0] blk,
                          input logic f);
    logic [7:0] s;
    do_call(fn, x, blk, `FSC_FIRST_KEY_BYTE_VAL, `FSC_SP_OFFSET);
    bus_rd(`FSC_REG_STATUS, s);
    `CHK("fail flag", f, s[`FSC_STATUS_FAIL])
    `CHK("accumulator", 8'h00, acc)
    if (f) begin
      `CHK("first key", 8'h01, fsc_sram_model_inst.mem[16'h00f8])
      `CHK("second key", 8'h00, fsc_sram_model_inst.mem[16'h00f9])
    end
  endtask : call_chk

  task automatic chk_blk(input logic [2:0] b, input logic zero);
    logic [7:0] d;
    for (int i = 0; i < 128; i++) begin
      tbl_read({b, i[6:0]}, d);
      `CHK("flash byte", zero ? 8'h00 : (i[7:0] ^ 8'h5c), d)
    end
  endtask : chk_blk

  // Source wraps inside its page, so the pointer near the top tests wrap
  task automatic fill_src();
    logic [7:0] a;
    for (int i = 0; i < 128; i++) begin
      a = PTR + i[7:0];
      fsc_sram_model_inst.mem[{8'h03, a}] = i[7:0] ^ 8'h5c;
    end
  endtask : fill_src

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_program();
    logic [7:0] d;
    bus_wr(`FSC_REG_PAGE, 8'h03);
    bus_rd(`FSC_REG_PAGE, d);
    `CHK("page register", 8'h03, d)
    // A write while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(`FSC_REG_PAGE, 8'h77);
    ce <= 1'b1;
    bus_rd(`FSC_REG_PAGE, d);
    `CHK("frozen page write", 8'h03, d)
    fill_src();
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h02, 1'b0);
    chk_blk(3'h2, 1'b0);
    call_chk(`FSC_FN_CLEAR, 1'b0, 8'h01, 1'b0);
    chk_blk(3'h1, 1'b1);
    $display("program and clear test done");
  endtask : t_program

  task automatic t_protect();
    fsc_sram_model_inst.mem[16'h03c0] = 8'he4;
    fsc_sram_model_inst.mem[16'h03c1] = 8'h00;
    call_chk(`FSC_FN_PROTECT, 1'b0, 8'h00, 1'b0);
    fill_src();
    call_chk(`FSC_FN_CLEAR, 1'b1, 8'h02, 1'b1);
    chk_blk(3'h2, 1'b0);
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h03, 1'b1);
    call_chk(`FSC_FN_CLEAR, 1'b0, 8'h03, 1'b1);
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h02, 1'b0);
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h01, 1'b0);
    chk_blk(3'h1, 1'b0);
    $display("protection test done");
  endtask : t_protect

  task automatic t_keys();
    logic [7:0] s;
    sp <= 8'hfe;
    // Let the new stack pointer settle before the keys are built from it
    @(posedge clk);
    do_call(`FSC_FN_PROGRAM, 1'b0, 8'h00, 8'h3b, `FSC_SP_OFFSET);
    `CHK("bad first key", 8'h01, fsc_sram_model_inst.mem[16'h00f8])
    do_call(`FSC_FN_PROGRAM, 1'b0, 8'h00, `FSC_FIRST_KEY_BYTE_VAL, 8'h04);
    bus_rd(`FSC_REG_STATUS, s);
    `CHK("bad second key", 1'b1, s[`FSC_STATUS_FAIL])
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h00, 1'b0);
    $display("key test done");
  endtask : t_keys

  task automatic t_table();
    logic [7:0] s;
    do_call(`FSC_FN_TABLE, 1'b0, 8'h02, `FSC_FIRST_KEY_BYTE_VAL, `FSC_SP_OFFSET);
    for (int k = 0; k < 8; k++) begin
      `CHK("table byte", 8'h10 + k[7:0], fsc_sram_model_inst.mem[16'h00f8 + k])
    end
    `CHK("revision", 8'h6b, acc)
    bus_rd(`FSC_REG_ACC, s);
    `CHK("revision register", 8'h6b, s)
    $display("table test done");
  endtask : t_table

  task automatic t_wipe();
    logic [7:0] s;
    call_chk(`FSC_FN_WIPE, 1'b1, 8'h00, 1'b0);
    chk_blk(3'h2, 1'b1);
    call_chk(`FSC_FN_PROGRAM, 1'b0, 8'h03, 1'b0);
    do_call(`FSC_FN_WIPE, 1'b0, 8'h00, `FSC_FIRST_KEY_BYTE_VAL, `FSC_SP_OFFSET);
    `CHK("halt", 1'b1, halt)
    bus_rd(`FSC_REG_STATUS, s);
    `CHK("halt flag", 1'b1, s[`FSC_STATUS_HALT])
    chk_blk(3'h3, 1'b0);
    $display("wipe test done");
  endtask : t_wipe

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Whole run needs about 5600 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    {rst_n, reg_wr, reg_rd, ext, tbl_rd} = '0;
    ce = 1'b1;
    {reg_addr, reg_wdata, tbl_addr} = '0;
    sp = 8'h40;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_program();
    t_protect();
    t_keys();
    t_table();
    t_wipe();
    final_report();
  end
endmodule : fsc_top_bench
`default_nettype wire
